// ---- hw/wbtf_fetch.sv ----
// wbtf_fetch: reads a wave block descriptor from waveform RAM and streams its slices.
// assumes a RAM read port with one cycle latency and a downstream consumer with ready.
`timescale 1ns/1ps
`default_nettype none
module wbtf_fetch (
    input  wire logic                  sys_clk,       // 125 MHz clock
    input  wire logic                  nrst,          // sync reset, low
    input  wire logic                  startReq,      // pulse: play a descriptor
    input  wire logic [3:0]            descNum,       // descriptor number
    input  wire logic                  advance_next_descriptor, // pulse: leave current block
    input  wire logic                  stopReq,       // pulse: stop playback
    output logic                       ramRd,         // RAM read strobe
    output logic [11:0]                ramAddr,       // RAM word address
    input  wire logic [15:0]           ramData,       // RAM data, one cycle after ramRd
    output logic [15:0]                wordData,      // slice word out
    output logic [1:0]                 wordIdx,       // word within slice 0..2
    output logic                       wordLast,      // last word of the range pass
    output logic                       wordValid,     // word available
    input  wire logic                  wordReady,     // consumer takes word
    output logic [3:0]                 ramp_up_shaping, // ramp-up field of current slice
    output logic                       busy,          // playback running
    output logic                       descError      // sticky: bad descriptor number
);
    typedef struct packed {
        wbtf_pkg::wbtf_state_t state;
        wbtf_pkg::wbtf_desc_t  desc;
        logic [11:0]           addr;
        logic [1:0]            dIdx;
        logic [1:0]            sIdx;
        logic [15:0]           pass;
        logic                  pend;
        logic [1:0]            pendIdx;
        logic                  pendLast;
        logic                  rd;
        logic [3:0]            shape;
        logic                  err;
    } wbtf_fetch_st_t;

    wbtf_fetch_st_t        st_ff, nxt_st;
    wbtf_pkg::wbtf_word_t  pushWord, popWord;
    logic                  pushReady, pushValid;
    logic [11:0]           fieldAddr;

    // descriptor base is 3n
    function automatic logic [11:0] descBase(input logic [3:0] n);
        descBase = wbtf_pkg::TABLE_BASE + wbtf_pkg::DESC_WORDS * {8'h00, n};
    endfunction : descBase

    assign fieldAddr = ramData[11:0];
    assign pushWord  = '{data: ramData, wordIdx: st_ff.pendIdx, lastWord: st_ff.pendLast};
    assign pushValid = st_ff.pend;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rd   = 1'b0;
        nxt_st.pend = 1'b0;
        case (st_ff.state)
            wbtf_pkg::WB_IDLE, wbtf_pkg::WB_ERR: begin
                if (startReq) begin
                    if (descNum > wbtf_pkg::MAX_DESC) begin
                        nxt_st.state = wbtf_pkg::WB_ERR;
                        nxt_st.err   = 1'b1;
                    end else begin
                        nxt_st.state = wbtf_pkg::WB_DESC;
                        nxt_st.addr  = descBase(descNum);
                        nxt_st.dIdx  = 2'h0;
                        nxt_st.rd    = 1'b1;
                        nxt_st.err   = 1'b0;
                    end
                end
            end
            wbtf_pkg::WB_DESC: begin
                if (!st_ff.rd) begin
                    // data of the previous read is present now
                    case (st_ff.dIdx)
                        2'h0: nxt_st.desc.firstPtr = fieldAddr;
                        2'h1: nxt_st.desc.lastPtr  = fieldAddr;
                        default: nxt_st.desc.count = ramData;
                    endcase
                    if (st_ff.dIdx == 2'h2) begin
                        nxt_st.state = wbtf_pkg::WB_SLICE;
                        nxt_st.addr  = st_ff.desc.firstPtr;
                        nxt_st.sIdx  = 2'h0;
                        nxt_st.pass  = 16'h0001;
                    end else begin
                        nxt_st.dIdx = st_ff.dIdx + 2'h1;
                        nxt_st.addr = st_ff.addr + 12'h001;
                        nxt_st.rd   = 1'b1;
                    end
                end
            end
            wbtf_pkg::WB_SLICE: begin
                // one read in flight at most; wait for FIFO room before issuing
                if (!st_ff.rd && !st_ff.pend && pushReady) begin
                    nxt_st.rd       = 1'b1;
                    nxt_st.pend     = 1'b0;
                end
                if (st_ff.rd) begin
                    nxt_st.pend     = 1'b1;
                    nxt_st.pendIdx  = st_ff.sIdx;
                    nxt_st.pendLast = (st_ff.addr == st_ff.desc.lastPtr);
                end
                if (st_ff.pend) begin
                    if (st_ff.pendIdx == wbtf_pkg::SLICE_WORDS - 2'h1) begin
                        nxt_st.shape = ramData[wbtf_pkg::SHAPE_HI:wbtf_pkg::SHAPE_LO];
                    end
                    if (st_ff.pendLast) begin
                        nxt_st.sIdx = 2'h0;
                        nxt_st.addr = st_ff.desc.firstPtr;
                        if (st_ff.desc.count != wbtf_pkg::COUNT_FOREVER &&
                            st_ff.pass == st_ff.desc.count) begin
                            nxt_st.state = wbtf_pkg::WB_IDLE;
                        end else begin
                            nxt_st.pass = st_ff.pass + 16'h0001;
                        end
                    end else begin
                        nxt_st.addr = st_ff.addr + 12'h001;
                        nxt_st.sIdx = (st_ff.sIdx == wbtf_pkg::SLICE_WORDS - 2'h1) ?
                                      2'h0 : st_ff.sIdx + 2'h1;
                    end
                end
            end
            default: nxt_st.state = wbtf_pkg::WB_IDLE;
        endcase
        if (stopReq || advance_next_descriptor) begin
            nxt_st.state = wbtf_pkg::WB_IDLE;
            nxt_st.rd    = 1'b0;
            nxt_st.pend  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ramRd           = st_ff.rd;
    assign ramAddr         = st_ff.addr;
    assign ramp_up_shaping = st_ff.shape;
    assign busy            = (st_ff.state == wbtf_pkg::WB_DESC) ||
                             (st_ff.state == wbtf_pkg::WB_SLICE);
    assign descError       = st_ff.err;
    assign wordData        = popWord.data;
    assign wordIdx         = popWord.wordIdx;
    assign wordLast        = popWord.lastWord;

    // a pending word always finds room: reads issue only while the FIFO has space
    wbtf_fifo #(
        .WIDTH ($bits(wbtf_pkg::wbtf_word_t)),
        .DEPTH (wbtf_pkg::FIFO_DEPTH),
        .AW    (wbtf_pkg::FIFO_AW)
    ) uFifo (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .inData   (pushWord),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .outData  (popWord),
        .outValid (wordValid),
        .outReady (wordReady)
    );

    chk_range_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
        (ramRd && st_ff.state == wbtf_pkg::WB_DESC) |-> (ramAddr <= wbtf_pkg::TABLE_LAST + 12'h002))
        else $error("descriptor read outside table");
    chk_bad_num: assert property (@(posedge sys_clk) disable iff (!nrst)
        (startReq && !busy && descNum > wbtf_pkg::MAX_DESC && !stopReq && !advance_next_descriptor)
        |=> (descError && !ramRd))
        else $error("invalid descriptor number accepted");
    chk_desc_base: assert property (@(posedge sys_clk) disable iff (!nrst)
        (startReq && !busy && descNum <= wbtf_pkg::MAX_DESC && !stopReq && !advance_next_descriptor)
        |=> (ramRd && ramAddr == 12'($past(descNum)) * 12'h003))
        else $error("descriptor base not at 3n");
    chk_stop_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
        (stopReq || advance_next_descriptor) |=> (!busy && !ramRd))
        else $error("stop did not end playback");
    chk_shape_src: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_ff.pend && st_ff.pendIdx == 2'h2 && !stopReq && !advance_next_descriptor)
        |=> (ramp_up_shaping == $past(ramData[7:4])))
        else $error("ramp-up field not taken from bits 7:4");

    // descriptor words land in the right fields; the top nibble of pointers is dropped
    chk_first_ptr: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_ff.state == wbtf_pkg::WB_DESC && !st_ff.rd && st_ff.dIdx == 2'h0)
        |=> (st_ff.desc.firstPtr == $past(ramData[11:0])))
        else $error("first-slice pointer not taken from bits 11:0");
    chk_last_ptr: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_ff.state == wbtf_pkg::WB_DESC && !st_ff.rd && st_ff.dIdx == 2'h1)
        |=> (st_ff.desc.lastPtr == $past(ramData[11:0])))
        else $error("last-slice pointer not taken from the second word");
    chk_repeat_word: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_ff.state == wbtf_pkg::WB_DESC && !st_ff.rd && st_ff.dIdx == 2'h2)
        |=> (st_ff.desc.count == $past(ramData)))
        else $error("repeat count not taken from the third word");

    // the slice range starts at the first pointer and wraps back to it after each pass
    chk_slice_begin: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_ff.state == wbtf_pkg::WB_DESC && !st_ff.rd && st_ff.dIdx == 2'h2 &&
         !stopReq && !advance_next_descriptor)
        |=> (st_ff.state == wbtf_pkg::WB_SLICE && ramAddr == st_ff.desc.firstPtr))
        else $error("slice fetch did not begin at the first pointer");
    chk_forever_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_ff.state == wbtf_pkg::WB_SLICE && st_ff.pend && st_ff.pendLast &&
         st_ff.desc.count == wbtf_pkg::COUNT_FOREVER && !stopReq && !advance_next_descriptor)
        |=> (busy && ramAddr == st_ff.desc.firstPtr))
        else $error("endless block did not wrap to the first pointer");
    chk_pass_end: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_ff.state == wbtf_pkg::WB_SLICE && st_ff.pend && st_ff.pendLast &&
         st_ff.desc.count != wbtf_pkg::COUNT_FOREVER && st_ff.pass == st_ff.desc.count)
        |=> !busy)
        else $error("block kept playing after its repeat count");

    // a word that comes back from RAM always finds a free FIFO slot
    chk_fifo_room: assert property (@(posedge sys_clk) disable iff (!nrst)
        pushValid |-> pushReady)
        else $error("slice word arrived with the FIFO full");
endmodule : wbtf_fetch
`default_nettype wire

// ---- hw/wbtf_fifo.sv ----
// wbtf_fifo: flip-flop FIFO with valid/ready on both sides.
// assumes one clock domain; width and depth are parameters.
`timescale 1ns/1ps
`default_nettype none
module wbtf_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             sys_clk,  // clock
    input  wire logic             nrst,     // sync reset, low
    input  wire logic [WIDTH-1:0] inData,   // write data
    input  wire logic             inValid,  // write request
    output logic                  inReady,  // not full
    output logic      [WIDTH-1:0] outData,  // head word
    output logic                  outValid, // not empty
    input  wire logic             outReady  // consumer takes
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } wbtf_fifo_st_t;

    wbtf_fifo_st_t st_ff, nxt_st;
    logic          doWr, doRd;

    assign inReady  = (st_ff.cnt < (AW+1)'(DEPTH));
    assign outValid = (st_ff.cnt != '0);
    assign outData  = st_ff.mem[st_ff.rp];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    always_comb begin
        nxt_st = st_ff;
        if (doWr) begin
            nxt_st.mem[st_ff.wp] = inData;
            nxt_st.wp = st_ff.wp + AW'(1);
        end
        if (doRd) begin
            nxt_st.rp = st_ff.rp + AW'(1);
        end
        if (doWr && !doRd) begin
            nxt_st.cnt = st_ff.cnt + (AW+1)'(1);
        end else if (doRd && !doWr) begin
            nxt_st.cnt = st_ff.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : wbtf_fifo
`default_nettype wire

// ---- inc/wbtf_pkg.sv ----
// wbtf_pkg: constants and types for the wave block table fetch block.
// assumes a single 125 MHz clock and a 16-bit synchronous waveform RAM read port.
package wbtf_pkg;
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 16;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          FIFO_AW      = 4;
    localparam logic [3:0]  MAX_DESC     = 4'he;
    localparam logic [11:0] TABLE_BASE   = 12'h000;
    localparam logic [11:0] TABLE_LAST   = 12'h02a;
    localparam logic [11:0] DESC_WORDS   = 12'h003;
    localparam logic [1:0]  SLICE_WORDS  = 2'h3;
    localparam int          SHAPE_HI     = 7;
    localparam int          SHAPE_LO     = 4;
    localparam logic [15:0] COUNT_FOREVER = 16'h0000;

    typedef enum logic [2:0] {
        WB_IDLE, WB_DESC, WB_SLICE, WB_ERR
    } wbtf_state_t;

    typedef struct packed {
        logic [15:0] data;
        logic [1:0]  wordIdx;
        logic        lastWord;
    } wbtf_word_t;

    typedef struct packed {
        logic [11:0] firstPtr;
        logic [11:0] lastPtr;
        logic [15:0] count;
    } wbtf_desc_t;
endpackage : wbtf_pkg

// ---- verif/wave_block_table_fetch_bench.sv ----
// wave_block_table_fetch_bench: self-checking bench for wbtf_fetch.
// assumes the fetch block's own assertions; the bench models the RAM read port.
`timescale 1ns/1ps
`default_nettype none
module wave_block_table_fetch_bench;
    logic        sysClk, nrst, startReq, advNext, stopReq, ramRd;
    logic        wordLast, wordValid, wordReady, busy, descError;
    logic [3:0]  descNum, rampUp;
    logic [11:0] ramAddr;
    logic [15:0] ramData, wordData;
    logic [1:0]  wordIdx;
    logic [15:0] mem [0:4095];
    int          error_cnt, check_count;

    wbtf_fetch wbtf_fetch_i (
        .sys_clk(sysClk), .nrst(nrst), .startReq(startReq), .descNum(descNum),
        .advance_next_descriptor(advNext), .stopReq(stopReq), .ramRd(ramRd),
        .ramAddr(ramAddr), .ramData(ramData), .wordData(wordData), .wordIdx(wordIdx),
        .wordLast(wordLast), .wordValid(wordValid), .wordReady(wordReady),
        .ramp_up_shaping(rampUp), .busy(busy), .descError(descError)
    );

    initial begin
        sysClk = 1'b0;
        forever #4 sysClk = ~sysClk;
    end

    // unread cycles show the inverse so stale data never looks valid
    always @(posedge sysClk) ramData <= ramRd ? mem[ramAddr] : ~ramData;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic start(input logic [3:0] n);
        @(posedge sysClk);
        startReq <= 1'b1;
        descNum  <= n;
        @(posedge sysClk);
        startReq <= 1'b0;
    endtask : start

    // cnt 0 plays two passes and a bit, then aborts by stop or advance
    task automatic play(input logic [3:0] n, input logic [11:0] fp, input logic [11:0] lp,
                        input logic [15:0] cnt, input bit useAdv);
        int len, tot, k, t, e;
        len = lp - fp + 1;
        tot = (cnt == 16'h0000) ? 2 * len + 2 : len * cnt;
        mem[3*n]   = {4'hf, fp};
        mem[3*n+1] = {4'ha, lp};
        mem[3*n+2] = cnt;
        for (int i = 0; i < len; i++) mem[fp+i] = 16'h5a00 ^ 16'(i * 19);
        start(n);
        t = 0;
        do begin
            @(negedge sysClk);
            t++;
        end while (ramRd !== 1'b1 && t < 20);
        check("descAddr", {4'h0, ramAddr}, 16'(3 * n));
        check("descError", {15'h0, descError}, 16'h0000);
        k = 0;
        t = 0;
        while (k < tot && t < 5000) begin
            @(posedge sysClk);
            wordReady <= (t % 3 != 0);
            @(negedge sysClk);
            if (wordValid === 1'b1 && wordReady === 1'b1) begin
                e = k % len;
                check("wordData", wordData, mem[fp+e]);
                check("wordIdx", {14'h0, wordIdx}, 16'(e % 3));
                check("wordLast", {15'h0, wordLast}, 16'(e == len - 1));
                k++;
            end
            t++;
        end
        check("wordCount", 16'(k), 16'(tot));
        if (cnt == 16'h0000) begin
            @(posedge sysClk);
            if (useAdv) advNext <= 1'b1;
            else stopReq <= 1'b1;
            @(posedge sysClk);
            advNext <= 1'b0;
            stopReq <= 1'b0;
        end
        @(posedge sysClk);
        wordReady <= 1'b1;
        e = 0;
        repeat (40) begin
            @(negedge sysClk);
            if (wordValid === 1'b1) e++;
        end
        @(negedge sysClk);
        check("busyEnd", {15'h0, busy}, 16'h0000);
        if (cnt != 16'h0000)
            check("extraWords", 16'(e), 16'h0000);
        if (cnt != 16'h0000)
            check("rampUp", {12'h0, rampUp}, {12'h0, mem[lp][7:4]});
        $display("test desc %h count %h done", n, cnt);
    endtask : play

    task automatic bad_desc();
        int reads;
        reads = 0;
        start(4'hf);
        repeat (12) begin
            @(negedge sysClk);
            if (ramRd === 1'b1) reads++;
        end
        check("badReads", 16'(reads), 16'h0000);
        check("descError", {15'h0, descError}, 16'h0001);
        check("busyBad", {15'h0, busy}, 16'h0000);
        $display("test bad descriptor done");
    endtask : bad_desc

    initial begin
        error_cnt = 0;
        check_count = 0;
        nrst = 1'b0;
        startReq = 1'b0;
        descNum = 4'h0;
        advNext = 1'b0;
        stopReq = 1'b0;
        wordReady = 1'b0;
        repeat (6) @(posedge sysClk);
        nrst <= 1'b1;
        bad_desc();
        play(4'h2, 12'h100, 12'h105, 16'h0002, 1'b0);
        play(4'he, 12'h200, 12'h202, 16'h0000, 1'b0);
        play(4'h0, 12'h030, 12'h035, 16'h0000, 1'b1);
        play(4'h7, 12'h3f0, 12'h3f2, 16'h0003, 1'b0);
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge sysClk);
        error_cnt++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule : wave_block_table_fetch_bench
`default_nettype wire
